// ==== rtl/lics_top.sv ====
// Purpose: charge sequencer: trickle, fast and float phases, timer, status and lockouts
// Assumes: comparator flags are asynchronous; cc_ratio_i is from logic on clk_i
// Notes:   analog regulation loops sit outside; this block only steers them
//
// The address map and the Wishbone slave port were decided locally.
`timescale 1ns/1ps

module lics_top #(
  parameter int TICK_CYCLES = lics_pkg::TICK_CYCLES_DEF,
  parameter int FULL_TICKS  = lics_pkg::FULL_TICKS_DEF,
  parameter bit UV_REDUCE   = 1'b1
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // wishbone slave
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [31:0]          wb_dat_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic                 wb_we_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  // comparator flags and delivered current fraction
  input  wire lics_pkg::lics_flags_t flags_i,
  input  wire logic [7:0]           cc_ratio_i,
  // charger controls
  output logic                      charge_en_o,
  output logic                      trickle_o,
  output logic                      uv_reduce_en_o,
  output logic                      in_path_en_o,
  output logic                      low_power_o,
  output logic                      ideal_diode_en_o,
  // status
  output logic                      charge_status_n_o,
  output logic                      charge_status_oe_o,
  output logic                      eoc_o,
  output logic                      defective_o
);
  import lics_pkg::*;

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  generate
    if (TICK_CYCLES < 1 || FULL_TICKS < 4 || FULL_TICKS >= (1 << TMR_W)) begin : g_bad
      $error("lics_top: tick or timer length out of range");
    end
  endgenerate

  localparam logic [TMR_W-1:0] FULL_LIM = TMR_W'(FULL_TICKS);
  localparam logic [TMR_W-1:0] HALF_LIM = TMR_W'(FULL_TICKS / 2);
  localparam logic [31:0]      TICK_MAX = 32'(TICK_CYCLES - 1);

  // ----------------------------------------------------------------
  // flag synchroniser
  // ----------------------------------------------------------------
  logic [FLAG_W-1:0] sync1, sync2, sync3, flt;
  logic [FLAG_W-1:0] next_flt;
  lics_flags_t       f;

  always_comb begin
    // a bit moves only when stages two and three agree
    next_flt = (flt & (sync2 ^ sync3)) | (sync3 & ~(sync2 ^ sync3));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      flt   <= '0;
    end else begin
      sync1 <= flags_i;
      sync2 <= sync1;
      sync3 <= sync2;
      flt   <= next_flt;
    end
  end

  assign f = lics_flags_t'(flt);

  // ----------------------------------------------------------------
  // tick divider
  // ----------------------------------------------------------------
  logic [31:0] div_cnt, next_div_cnt;
  logic        tick;

  always_comb begin
    next_div_cnt = (div_cnt == TICK_MAX) ? 32'h0 : div_cnt + 32'h1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) div_cnt <= 32'h0;
    else       div_cnt <= next_div_cnt;
  end

  assign tick = (div_cnt == TICK_MAX);

  // ----------------------------------------------------------------
  // wishbone registers
  // ----------------------------------------------------------------
  logic        ctrl_en, next_ctrl_en;
  logic        sw_restart, next_sw_restart;
  logic        next_ack;
  logic [31:0] next_dat;
  lics_state_t state, next_state;
  logic [TMR_W-1:0] elapsed, next_elapsed, limit, next_limit;
  logic        eoc, next_eoc, defect, next_defect;

  always_comb begin
    next_ack        = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    next_ctrl_en    = ctrl_en;
    next_sw_restart = 1'b0;
    next_dat        = 32'h0;
    if (next_ack) begin
      if (wb_we_i && wb_adr_i == ADDR_CTRL && wb_sel_i[0]) begin
        next_ctrl_en    = wb_dat_i[CTRL_EN_BIT];
        next_sw_restart = wb_dat_i[CTRL_RST_BIT];
      end
      if (!wb_we_i) begin
        case (wb_adr_i)
          ADDR_CTRL:    next_dat = {31'h0, ctrl_en};
          ADDR_STATUS:  next_dat = {14'h0, flt, defect, eoc, state};
          ADDR_ELAPSED: next_dat = {8'h0, elapsed};
          ADDR_LIMIT:   next_dat = {8'h0, limit};
          default:      next_dat = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h0;
      ctrl_en    <= CTRL_EN_RST;
      sw_restart <= 1'b0;
    end else begin
      wb_ack_o   <= next_ack;
      wb_dat_o   <= next_dat;
      ctrl_en    <= next_ctrl_en;
      sw_restart <= next_sw_restart;
    end
  end

  // ----------------------------------------------------------------
  // lockout latches
  // ----------------------------------------------------------------
  logic in_rev_lock, next_in_rev_lock, chg_rev_lock, next_chg_rev_lock;

  always_comb begin
    next_in_rev_lock  = in_rev_lock;
    next_chg_rev_lock = chg_rev_lock;
    if (f.out_below_in_50) next_in_rev_lock = 1'b0;
    if (f.out_gt_in)       next_in_rev_lock = 1'b1;
    if (f.out_gt_batt_50)  next_chg_rev_lock = 1'b0;
    if (f.batt_gt_out)     next_chg_rev_lock = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_rev_lock  <= 1'b1;
      chg_rev_lock <= 1'b1;
    end else begin
      in_rev_lock  <= next_in_rev_lock;
      chg_rev_lock <= next_chg_rev_lock;
    end
  end

  // ----------------------------------------------------------------
  // sequencer and timer
  // ----------------------------------------------------------------
  logic       run_ok, run_prev, start_evt, advance, expired;
  logic [7:0] acc, next_acc, eff_ratio;
  logic [8:0] acc_sum;

  function automatic lics_state_t first_phase(input logic low);
    first_phase = low ? LICS_TRICKLE : LICS_FAST;
  endfunction

  // timer pin at ground and output lockout are shutdown
  assign run_ok    = f.out_lockout_ok & ~f.timer_disable & ctrl_en & ~chg_rev_lock;
  assign start_evt = run_ok & (~run_prev | sw_restart);
  assign expired   = (elapsed >= limit);
  // taper in float keeps full speed; only fast phase scales
  assign eff_ratio = (state == LICS_FAST && !f.cv_mode) ? cc_ratio_i : RATIO_FULL;
  assign acc_sum   = {1'b0, acc} + {1'b0, eff_ratio};
  assign advance   = tick & ((eff_ratio == RATIO_FULL) | acc_sum[8]);

  always_comb begin
    next_state   = state;
    next_elapsed = elapsed;
    next_limit   = limit;
    next_eoc     = eoc;
    next_defect  = defect;
    next_acc     = (tick && eff_ratio != RATIO_FULL) ? acc_sum[7:0] : acc;
    if (!run_ok) begin
      next_state   = LICS_OFF;
      next_elapsed = '0;
    end else if (start_evt) begin
      next_eoc     = 1'b0;
      next_defect  = 1'b0;
      next_elapsed = '0;
      next_acc     = 8'h0;
      next_limit   = FULL_LIM;
      next_state   = f.batt_below_rchg ? first_phase(f.batt_low) : LICS_DONE;
    end else begin
      case (state)
        LICS_TRICKLE: begin
          if (advance && !expired) next_elapsed = elapsed + 1'b1;
          if (elapsed >= (limit >> 2)) begin
            next_state  = LICS_DEFECT;
            next_defect = 1'b1;
          end else if (!f.batt_low) begin
            next_state = LICS_FAST;
          end
        end
        LICS_FAST: begin
          if (advance && !expired) next_elapsed = elapsed + 1'b1;
          if (expired) begin
            next_elapsed = '0;
            if (f.batt_below_rchg) begin
              next_limit = HALF_LIM;
              next_eoc   = 1'b0;
              next_state = first_phase(f.batt_low);
            end else begin
              next_state = LICS_DONE;
            end
          end
          // set wins over a same-cycle recharge clear
          if (f.cv_mode && f.cur_below_10) next_eoc = 1'b1;
        end
        LICS_DONE: begin
          if (f.batt_below_rchg) begin
            next_limit   = HALF_LIM;
            next_elapsed = '0;
            next_eoc     = 1'b0;
            next_state   = first_phase(f.batt_low);
          end
        end
        LICS_DEFECT: begin
          if (!f.batt_low) begin
            next_defect  = 1'b0;
            next_elapsed = '0;
            next_limit   = FULL_LIM;
            next_state   = LICS_FAST;
          end
        end
        default: next_state = LICS_OFF;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state    <= LICS_OFF;
      elapsed  <= '0;
      limit    <= '0;
      eoc      <= 1'b0;
      defect   <= 1'b0;
      acc      <= 8'h0;
      run_prev <= 1'b0;
    end else begin
      state    <= next_state;
      elapsed  <= next_elapsed;
      limit    <= next_limit;
      eoc      <= next_eoc;
      defect   <= next_defect;
      acc      <= next_acc;
      run_prev <= run_ok;
    end
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  logic charging;
  logic next_charge_en, next_trickle, next_uvr, next_in_path, next_low_power;
  logic next_diode, next_status_oe;

  assign charging = (state == LICS_TRICKLE) || (state == LICS_FAST);

  always_comb begin
    next_charge_en = charging & run_ok & f.out_headroom;
    next_trickle   = (state == LICS_TRICKLE);
    next_uvr       = UV_REDUCE & charging;
    // suspend only touches the input side
    next_in_path   = f.in_lockout_ok & ~in_rev_lock & ~f.suspend_request;
    next_low_power = f.suspend_request;
    next_diode     = f.batt_gt_out & ~f.batt_low;
    next_status_oe = charging & ~eoc;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      charge_en_o        <= 1'b0;
      trickle_o          <= 1'b0;
      uv_reduce_en_o     <= 1'b0;
      in_path_en_o       <= 1'b0;
      low_power_o        <= 1'b0;
      ideal_diode_en_o   <= 1'b0;
      charge_status_oe_o <= 1'b0;
      charge_status_n_o  <= 1'b0;
      eoc_o              <= 1'b0;
      defective_o        <= 1'b0;
    end else begin
      charge_en_o        <= next_charge_en;
      trickle_o          <= next_trickle;
      uv_reduce_en_o     <= next_uvr;
      in_path_en_o       <= next_in_path;
      low_power_o        <= next_low_power;
      ideal_diode_en_o   <= next_diode;
      charge_status_oe_o <= next_status_oe;
      charge_status_n_o  <= 1'b0;
      eoc_o              <= eoc;
      defective_o        <= defect;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  start_qualified_a: assert property (!($past(state) inside {LICS_OFF, LICS_DONE}) ||
      !(state inside {LICS_TRICKLE, LICS_FAST}) || $past(f.out_lockout_ok && f.batt_below_rchg))
    else $error("cycle started without qualification");
  headroom_gate_a: assert property (charge_en_o |-> $past(f.out_headroom && f.out_lockout_ok))
    else $error("charge current without headroom");
  trickle_limit_a: assert property (state == LICS_TRICKLE |=> trickle_o)
    else $error("trickle limit not applied");
  fast_move_a: assert property (state == LICS_TRICKLE && !f.batt_low && run_ok && !start_evt
      && elapsed < (limit >> 2) |=> state == LICS_FAST)
    else $error("no move to fast charge");
  eoc_release_a: assert property (eoc && run_ok |=> !charge_status_oe_o)
    else $error("status held low after end of charge");
  eoc_latch_a: assert property (eoc && state == LICS_FAST && run_ok && !start_evt && !expired
      |=> eoc)
    else $error("end of charge latch lost");
  defect_time_a: assert property (state == LICS_DEFECT && $past(state) == LICS_TRICKLE
      |-> $past(elapsed) >= ($past(limit) >> 2) && defect)
    else $error("defect flagged early");
  timer_off_a: assert property (f.timer_disable |=> state == LICS_OFF ##1 !charge_en_o)
    else $error("charger on with timer grounded");
  float_speed_a: assert property (state == LICS_FAST && f.cv_mode && tick && !expired
      && run_ok && !start_evt |=> elapsed == $past(elapsed) + 1'b1)
    else $error("timer slowed in constant voltage");

  trickle_fast_c: cover property (state == LICS_TRICKLE ##1 state == LICS_FAST);
  eoc_seen_c:     cover property ($rose(eoc));
  defect_seen_c:  cover property ($rose(defect));
  recharge_c:     cover property (state == LICS_DONE ##1 state inside {LICS_TRICKLE, LICS_FAST});

endmodule

// ==== rtl/lics_pkg.sv ====
// Purpose: shared constants and types for the li-ion charge sequencer
// Assumes: 200 MHz system clock, comparator flags arrive as asynchronous levels
// Notes:   timer ticks are 1 ms enable pulses from a divider
package lics_pkg;

  // ----------------------------------------------------------------
  // clock and timebase
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_HZ     = 200_000_000;
  localparam int TICK_TIME_US    = 1000;
  localparam int TICK_CYCLES_DEF = TICK_TIME_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int FULL_TIME_S     = 10800;
  localparam int FULL_TICKS_DEF  = FULL_TIME_S * (1_000_000 / TICK_TIME_US);
  localparam int TMR_W           = 24;

  // ----------------------------------------------------------------
  // register map (byte addresses) and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_STATUS  = 8'h04;
  localparam logic [7:0]  ADDR_ELAPSED = 8'h08;
  localparam logic [7:0]  ADDR_LIMIT   = 8'h0c;
  localparam int          CTRL_EN_BIT  = 0;
  localparam int          CTRL_RST_BIT = 1;
  localparam logic        CTRL_EN_RST  = 1'b1;
  localparam logic [7:0]  RATIO_FULL   = 8'hff;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LICS_OFF     = 3'b000,
    LICS_TRICKLE = 3'b001,
    LICS_FAST    = 3'b010,
    LICS_DONE    = 3'b011,
    LICS_DEFECT  = 3'b100
  } lics_state_t;

  typedef struct packed {
    logic out_lockout_ok;    // output above undervoltage_lockout level
    logic out_headroom;      // output at least 100mV above battery_node
    logic out_gt_batt_50;    // output above battery_node by 50mV
    logic batt_gt_out;       // battery_node above output
    logic in_lockout_ok;     // input above its lockout level
    logic out_gt_in;         // output above input
    logic out_below_in_50;   // output 50mV below input
    logic batt_low;          // battery_node below 2.8V
    logic batt_below_rchg;   // battery_node below recharge threshold
    logic cur_below_10;      // charge current below 10% of set value
    logic cv_mode;           // regulation loop in constant voltage
    logic suspend_request;   // suspend pin above 1.2V
    logic timer_disable;     // timer pin held at ground
  } lics_flags_t;

  localparam int FLAG_W = $bits(lics_flags_t);

endpackage

// ==== dv/tb_lics_top.sv ====
// Purpose: self-checking bench for the charge sequencer
// Assumes: shortened timer (4-cycle tick, 64-tick cycle), all flags driven directly
// Notes:   expected phase is passed to each status check as an integer and compared there
`timescale 1ns/1ps

module tb_lics_top;
  import lics_pkg::*;

  localparam int TCK  = 4;
  localparam int FULL = 64;

  logic        clk_i      = 1'b0;
  logic        rst_i      = 1'b1;
  logic [7:0]  wb_adr_i   = 8'h00;
  logic [31:0] wb_dat_i   = 32'h0;
  logic [3:0]  wb_sel_i   = 4'h0;
  logic        wb_we_i    = 1'b0;
  logic        wb_cyc_i   = 1'b0;
  logic        wb_stb_i   = 1'b0;
  lics_flags_t flags      = '0;
  logic [7:0]  cc_ratio_i = 8'hff;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, charge_en_o, trickle_o, uv_reduce_en_o, in_path_en_o, low_power_o;
  logic        ideal_diode_en_o, charge_status_n_o, charge_status_oe_o, eoc_o, defective_o;
  logic [31:0] rd;
  int          mismatches   = 0;
  int          total_checks = 0;
  int          seed         = 32'h021208b9;

  always #2.5 clk_i = ~clk_i;

  lics_top #(.TICK_CYCLES(TCK), .FULL_TICKS(FULL), .UV_REDUCE(1'b1)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .flags_i(flags), .cc_ratio_i(cc_ratio_i), .charge_en_o(charge_en_o),
    .trickle_o(trickle_o), .uv_reduce_en_o(uv_reduce_en_o), .in_path_en_o(in_path_en_o),
    .low_power_o(low_power_o), .ideal_diode_en_o(ideal_diode_en_o),
    .charge_status_n_o(charge_status_n_o), .charge_status_oe_o(charge_status_oe_o),
    .eoc_o(eoc_o), .defective_o(defective_o));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // classic cycle; request held until ack is sampled, then released for a cycle
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hf;
    // no wait-state count assumed; only the watchdog ends a hung access
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rdreg(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    check(rd, exp);
  endtask

  // flags pass a 3-flop filter, so give them ample time
  task automatic settle();
    repeat (10) @(posedge clk_i);
  endtask

  task automatic chk_outs(input int st, input logic eoc, input logic def);
    logic run;
    run = (st == 1 || st == 2);
    wb(1'b0, ADDR_STATUS, 32'h0);
    check({27'h0, rd[4:0]}, {27'h0, def, eoc, st[2:0]});
    check({19'h0, rd[17:5]}, {19'h0, flags});
    check(charge_en_o, run & flags.out_headroom);
    check(trickle_o, st == 1);
    check(charge_status_oe_o, run & ~eoc);
    check(uv_reduce_en_o, run);
    check(charge_status_n_o, 1'b0);
    check(eoc_o, eoc);
    check(defective_o, def);
  endtask

  task automatic wait_st(input int st);
    do begin
      wb(1'b0, ADDR_STATUS, 32'h0);
    end while (rd[2:0] !== st[2:0]);
  endtask

  // elapsed-tick gain over 16 ticks; two ticks of slack either way for window alignment
  task automatic meas(input int ex);
    int e0;
    int e1;
    wb(1'b0, ADDR_ELAPSED, 32'h0);
    e0 = int'(rd[23:0]);
    repeat (16 * TCK) @(posedge clk_i);
    wb(1'b0, ADDR_ELAPSED, 32'h0);
    e1 = int'(rd[23:0]);
    check(32'((e1 - e0 - ex) >= -2 && (e1 - e0 - ex) <= 2), 32'h1);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #50000;
    mismatches++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk_outs(0, 1'b0, 1'b0);
    rdreg(ADDR_CTRL, 32'h1);
    rdreg(8'h10, 32'h0);
    wb(1'b1, ADDR_STATUS, 32'hffffffff);
    rdreg(ADDR_STATUS, 32'h0);
    flags <= '{out_gt_batt_50:1'b1, out_headroom:1'b1, in_lockout_ok:1'b1, out_below_in_50:1'b1,
               batt_low:1'b1, batt_below_rchg:1'b1, default:1'b0};
    settle();
    chk_outs(0, 1'b0, 1'b0);
    flags.out_lockout_ok <= 1'b1;
    settle();
    chk_outs(1, 1'b0, 1'b0);
    rdreg(ADDR_LIMIT, 32'(FULL));
    check(in_path_en_o, 1'b1);
    flags.batt_low <= 1'b0;
    settle();
    chk_outs(2, 1'b0, 1'b0);
    cc_ratio_i <= 8'($random(seed) & 32'h7f) | 8'h40;
    @(posedge clk_i);
    meas(int'(cc_ratio_i) * 16 / 256);
    flags.cv_mode <= 1'b1;
    cc_ratio_i <= 8'h10;
    settle();
    meas(16);
    flags.cur_below_10 <= 1'b1;
    settle();
    chk_outs(2, 1'b1, 1'b0);
    flags.cur_below_10 <= 1'b0;
    settle();
    chk_outs(2, 1'b1, 1'b0);
    flags.out_headroom <= 1'b0;
    settle();
    check(charge_en_o, 1'b0);
    flags.out_headroom <= 1'b1;
    flags.batt_below_rchg <= 1'b0;
    wait_st(3);
    chk_outs(3, 1'b1, 1'b0);
    flags.batt_below_rchg <= 1'b1;
    settle();
    chk_outs(2, 1'b0, 1'b0);
    rdreg(ADDR_LIMIT, 32'(FULL / 2));
    wb(1'b1, ADDR_CTRL, 32'h3);
    rdreg(ADDR_LIMIT, 32'(FULL));
    flags.timer_disable <= 1'b1;
    settle();
    chk_outs(0, 1'b0, 1'b0);
    flags.timer_disable <= 1'b0;
    flags.batt_low <= 1'b1;
    settle();
    chk_outs(1, 1'b0, 1'b0);
    rdreg(ADDR_LIMIT, 32'(FULL));
    wait_st(4);
    chk_outs(4, 1'b0, 1'b1);
    flags.batt_low <= 1'b0;
    settle();
    wb(1'b0, ADDR_STATUS, 32'h0);
    check(rd[2:0], 3'h2);
    rdreg(ADDR_LIMIT, 32'(FULL));
    flags.suspend_request <= 1'b1;
    settle();
    check({low_power_o, charge_en_o}, 2'b11);
    flags.batt_gt_out <= 1'b1;
    settle();
    check({ideal_diode_en_o, charge_en_o}, 2'b10);
    flags.batt_gt_out <= 1'b0;
    flags.out_gt_batt_50 <= 1'b0;
    settle();
    check(charge_en_o, 1'b0);
    flags.out_gt_batt_50 <= 1'b1;
    flags.suspend_request <= 1'b0;
    settle();
    check({low_power_o, charge_en_o}, 2'b01);
    flags.out_gt_in <= 1'b1;
    settle();
    check(in_path_en_o, 1'b0);
    flags.out_gt_in <= 1'b0;
    flags.out_below_in_50 <= 1'b0;
    settle();
    check(in_path_en_o, 1'b0);
    flags.out_below_in_50 <= 1'b1;
    settle();
    check(in_path_en_o, 1'b1);
    flags.in_lockout_ok <= 1'b0;
    settle();
    check(in_path_en_o, 1'b0);
    wb(1'b1, ADDR_CTRL, 32'h0);
    rdreg(ADDR_CTRL, 32'h0);
    chk_outs(0, 1'b0, 1'b0);
    flags.batt_below_rchg <= 1'b0;
    settle();
    wb(1'b1, ADDR_CTRL, 32'h1);
    settle();
    chk_outs(3, 1'b0, 1'b0);
    print_verdict();
  end

endmodule
